// file: src/wsg_pkg.sv
// Wait-state generator package: register map, fields, types
//
// Contract
// R1 - External accesses can be stretched by up to fourteen machine cycles.
// R2 - Slow device holds ready low; access keeps stretching until ready goes high.
// R3 - All fields zero gates the generator clock enable off to save power.
// R4 - Low config bits hold five independent 3-bit base counts, 0 to 7.
// R5 - After reset every base count field reads 7.
// R6 - Config bit 15 is extended program range select, resets to 0.
// R7 - Config bits 14:12 give base count for every I/O access.
// R8 - Config bits 11:9 give base count for upper data half.
// R9 - Config bits 8:6 give base count for lower data half.
// R10 - Config bits 5:3 give upper program count; range follows extended select.
// R11 - Config bits 2:0 give lower program count; range follows extended select.
// R12 - Control bit 0 doubles all counts, resets to 0, maximum fourteen.
// R13 - Control bits 15:1 read zero and ignore writes.
// R14 - Access picks its field, scales it, holds that many cycles, then samples ready.
package wsg_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int WSG_AW = 7;
  localparam int WSG_DW = 16;
  localparam logic [WSG_AW-1:0] WSG_CFG_ADDR = 7'h28;
  localparam logic [WSG_AW-1:0] WSG_CTRL_ADDR = 7'h2b;
  localparam logic [WSG_DW-1:0] WSG_CFG_RST = 16'h7fff;
  localparam logic [WSG_DW-1:0] WSG_CTRL_RST = 16'h0000;
  localparam logic [WSG_DW-1:0] WSG_CTRL_WMASK = 16'h0001;
  localparam logic [WSG_DW-1:0] WSG_FIELDS_MASK = 16'h7fff;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int WSG_FW = 3;
  localparam int WSG_CW = 4;
  localparam int WSG_XPA_BIT = 15;
  localparam int WSG_IO_LSB = 12;
  localparam int WSG_DHI_LSB = 9;
  localparam int WSG_DLO_LSB = 6;
  localparam int WSG_PHI_LSB = 3;
  localparam int WSG_PLO_LSB = 0;
  localparam int WSG_MULT_BIT = 0;
  localparam int WSG_PAW = 23;
  localparam int WSG_HALF_BIT = 15;
  localparam int WSG_EXT_BIT = 22;
  localparam logic [WSG_CW-1:0] WSG_MAX_WAIT = 4'he;
  localparam logic [WSG_CW-1:0] WSG_ONE = 4'h1;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    WSG_SP_IO = 2'h0,
    WSG_SP_DATA = 2'h1,
    WSG_SP_PROG = 2'h2
  } wsg_space_t;

  typedef enum logic [2:0] {
    WSG_ST_IDLE = 3'h1,
    WSG_ST_HOLD = 3'h2,
    WSG_ST_SAMP = 3'h4
  } wsg_fsm_t;

  typedef struct packed {
    logic start;
    wsg_space_t space;
    logic [WSG_PAW-1:0] addr;
  } wsg_acc_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [WSG_AW-1:0] addr;
    logic [WSG_DW-1:0] wdata;
  } wsg_mmr_t;

endpackage

// file: src/wsg_decode.sv
// Wait-state generator: range decode and count scaling
`timescale 1ns/1ps
`default_nettype none
module wsg_decode
  import wsg_pkg::*;
(
  input wire logic [WSG_DW-1:0] cfg,
  input wire logic dbl,
  input wire wsg_space_t space,
  input wire logic [WSG_PAW-1:0] addr,
  output logic [WSG_FW-1:0] base,
  output logic [WSG_CW-1:0] eff
);

  logic upper;

  // ************************************************************
  // Field select
  // ************************************************************
  always_comb begin
    upper = addr[WSG_HALF_BIT];
    base = cfg[WSG_IO_LSB +: WSG_FW]; // R7
    unique case (space)
      WSG_SP_IO: begin
        base = cfg[WSG_IO_LSB +: WSG_FW]; // R7
      end
      WSG_SP_DATA: begin
        base = upper ? cfg[WSG_DHI_LSB +: WSG_FW] : cfg[WSG_DLO_LSB +: WSG_FW]; // R8 R9
      end
      WSG_SP_PROG: begin
        if (cfg[WSG_XPA_BIT]) begin
          upper = addr[WSG_EXT_BIT]; // R6
        end
        base = upper ? cfg[WSG_PHI_LSB +: WSG_FW] : cfg[WSG_PLO_LSB +: WSG_FW]; // R10 R11
      end
      default: begin
        base = cfg[WSG_IO_LSB +: WSG_FW];
      end
    endcase
    eff = dbl ? {base, 1'b0} : {1'b0, base}; // R12 R14
  end

endmodule // wsg_decode
`default_nettype wire

// file: src/wsg_count.sv
// Wait-state generator: gated down counter
`timescale 1ns/1ps
`default_nettype none
module wsg_count
  import wsg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic en,
  input wire logic load,
  input wire logic [WSG_CW-1:0] load_val,
  output logic last
);

  typedef struct packed {
    logic [WSG_CW-1:0] cnt;
  } wsg_cnt_st_t;

  wsg_cnt_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = load_val;
    end else if (en && s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - WSG_ONE; // R14
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign last = (s_q.cnt == WSG_ONE);

endmodule // wsg_count
`default_nettype wire

// file: src/wsg_top.sv
// Wait-state generator: registers, access sequencing, checks
`timescale 1ns/1ps
`default_nettype none
module wsg_top
  import wsg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire wsg_mmr_t memory_mapped_register,
  output logic [WSG_DW-1:0] mmr_rdata,
  input wire wsg_acc_t acc,
  input wire logic ready,
  output logic bus_wait,
  output logic acc_done,
  output logic acc_busy,
  output logic gen_clk_en,
  output logic [WSG_DW-1:0] cfg_out,
  output logic dbl_out
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    wsg_fsm_t fsm;
    logic [WSG_DW-1:0] cfg;
    logic [WSG_DW-1:0] ctrl;
    logic [WSG_DW-1:0] rdata;
  } wsg_st_t;

  wsg_st_t s_q, s_d;
  logic [WSG_FW-1:0] base;
  logic [WSG_CW-1:0] eff;
  logic take;
  logic cnt_last;
  logic cfg_hit;
  logic ctrl_hit;

  // ************************************************************
  // Decode and counter
  // ************************************************************
  wsg_decode u_decode (
    .cfg(s_q.cfg),
    .dbl(s_q.ctrl[WSG_MULT_BIT]),
    .space(acc.space),
    .addr(acc.addr),
    .base(base),
    .eff(eff)
  );

  assign gen_clk_en = |(s_q.cfg & WSG_FIELDS_MASK); // R3
  assign take = acc.start && (s_q.fsm == WSG_ST_IDLE);

  wsg_count u_count (
    .sys_clk(sys_clk),
    .srst(srst),
    .en(gen_clk_en), // R3
    .load(take),
    .load_val(eff),
    .last(cnt_last)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    cfg_hit = (memory_mapped_register.addr == WSG_CFG_ADDR);
    ctrl_hit = (memory_mapped_register.addr == WSG_CTRL_ADDR);
    if (memory_mapped_register.wr && cfg_hit) begin
      s_d.cfg = memory_mapped_register.wdata; // R4 R6
    end
    if (memory_mapped_register.wr && ctrl_hit) begin
      s_d.ctrl = memory_mapped_register.wdata & WSG_CTRL_WMASK; // R12 R13
    end
    if (memory_mapped_register.rd) begin
      s_d.rdata = cfg_hit ? s_q.cfg : (ctrl_hit ? s_q.ctrl : '0);
    end
    unique case (s_q.fsm)
      WSG_ST_IDLE: begin
        if (take) begin
          s_d.fsm = (eff == '0) ? WSG_ST_SAMP : WSG_ST_HOLD; // R14
        end
      end
      WSG_ST_HOLD: begin
        if (cnt_last) begin
          s_d.fsm = WSG_ST_SAMP; // R1 R14
        end
      end
      WSG_ST_SAMP: begin
        if (ready) begin
          s_d.fsm = WSG_ST_IDLE; // R2
        end
      end
      default: begin
        s_d.fsm = WSG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q.fsm <= WSG_ST_IDLE;
      s_q.cfg <= WSG_CFG_RST; // R5 R6
      s_q.ctrl <= WSG_CTRL_RST; // R12 R13
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign mmr_rdata = s_q.rdata;
  assign cfg_out = s_q.cfg;
  assign dbl_out = s_q.ctrl[WSG_MULT_BIT];
  assign acc_busy = (s_q.fsm != WSG_ST_IDLE);
  assign acc_done = (s_q.fsm == WSG_ST_SAMP) && ready; // R2
  assign bus_wait = (s_q.fsm == WSG_ST_HOLD) || ((s_q.fsm == WSG_ST_SAMP) && !ready); // R2

  // ************************************************************
  // Helper logic for checks
  // ************************************************************
  logic [WSG_CW-1:0] held_q;
  logic [WSG_CW-1:0] want_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      held_q <= '0;
      want_q <= '0;
    end else if (take) begin
      held_q <= '0;
      want_q <= eff;
    end else if (s_q.fsm == WSG_ST_HOLD) begin
      held_q <= held_q + WSG_ONE;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // ************************************************************
  // Assertions
  // ************************************************************
  cfg_reset_a: assert property (disable iff (1'b0) $fell(srst) |-> s_q.cfg == WSG_CFG_RST) // R5
    else $error("config not all sevens after reset");
  xpa_reset_a: assert property (disable iff (1'b0) $fell(srst) |-> !s_q.cfg[WSG_XPA_BIT]) // R6
    else $error("extended select not clear after reset");
  ctrl_rsvd_a: assert property (s_q.ctrl[WSG_DW-1:1] == '0) // R13
    else $error("control reserved bits not zero");
  ctrl_write_a: assert property (memory_mapped_register.wr && memory_mapped_register.addr == WSG_CTRL_ADDR |=>
      s_q.ctrl == {15'h0000, $past(memory_mapped_register.wdata[0])}) // R12
    else $error("control write wrong");
  max_wait_a: assert property (eff <= WSG_MAX_WAIT) // R1
    else $error("effective count above fourteen");
  dbl_scale_a: assert property (s_q.ctrl[WSG_MULT_BIT] |-> eff == {base, 1'b0}) // R12
    else $error("doubled count wrong");
  gate_off_a: assert property ((s_q.cfg & WSG_FIELDS_MASK) == '0 |-> !gen_clk_en) // R3
    else $error("clock enable on with all fields zero");
  io_field_a: assert property (acc.space == WSG_SP_IO |->
      base == s_q.cfg[14:12]) // R7
    else $error("io field not selected");
  data_hi_a: assert property (acc.space == WSG_SP_DATA && acc.addr[15] |->
      base == s_q.cfg[11:9]) // R8
    else $error("upper data field not selected");
  data_lo_a: assert property (acc.space == WSG_SP_DATA && !acc.addr[15] |->
      base == s_q.cfg[8:6]) // R9
    else $error("lower data field not selected");
  prog_hi_a: assert property (acc.space == WSG_SP_PROG &&
      (s_q.cfg[15] ? acc.addr[22] : acc.addr[15]) |-> base == s_q.cfg[5:3]) // R10
    else $error("upper program field not selected");
  prog_lo_a: assert property (acc.space == WSG_SP_PROG &&
      !(s_q.cfg[15] ? acc.addr[22] : acc.addr[15]) |-> base == s_q.cfg[2:0]) // R11
    else $error("lower program field not selected");
  hold_len_a: assert property ($rose(s_q.fsm == WSG_ST_SAMP) |-> held_q == want_q) // R14
    else $error("hold length differs from effective count");
  zero_wait_a: assert property (take && eff == '0 |=> s_q.fsm == WSG_ST_SAMP) // R14
    else $error("zero count access did not sample at once");
  ready_hold_a: assert property (s_q.fsm == WSG_ST_SAMP && !ready |=>
      s_q.fsm == WSG_ST_SAMP && acc_busy) // R2
    else $error("access ended without ready");
  done_once_a: assert property (acc_done |=> !acc_done && !acc_busy) // R2
    else $error("done not single pulse");
  cfg_write_a: assert property (memory_mapped_register.wr && memory_mapped_register.addr == WSG_CFG_ADDR && !srst |=>
      s_q.cfg == $past(memory_mapped_register.wdata)) // R4
    else $error("config write wrong");
  cfg_read_a: assert property (memory_mapped_register.rd && memory_mapped_register.addr == WSG_CFG_ADDR && !srst |=>
      mmr_rdata == $past(s_q.cfg)) // R4
    else $error("config read wrong");
  ctrl_read_a: assert property (memory_mapped_register.rd && memory_mapped_register.addr == WSG_CTRL_ADDR && !srst |=>
      mmr_rdata == {15'h0000, $past(s_q.ctrl[WSG_MULT_BIT])}) // R13
    else $error("control read wrong");
  wait_start_a: assert property (take && eff != '0 |=> bus_wait && acc_busy) // R14
    else $error("nonzero count access not held");
  idle_quiet_a: assert property (!acc_busy |-> !bus_wait && !acc_done) // R2
    else $error("wait or done while idle");
  busy_hold_a: assert property (acc_busy && !acc_done |=> acc_busy) // R2
    else $error("access dropped before done");

  // ************************************************************
  // Covers
  // ************************************************************
  max_wait_c: cover property (take && eff == WSG_MAX_WAIT);
  ready_ext_c: cover property (s_q.fsm == WSG_ST_SAMP && !ready ##1 acc_done);
  ext_prog_c: cover property (take && s_q.cfg[WSG_XPA_BIT] && acc.space == WSG_SP_PROG);
  gated_c: cover property (take && !gen_clk_en);

endmodule // wsg_top
`default_nettype wire

// file: tb/wsg_ext_dev.sv
// External memory model that answers each access through the ready line
`timescale 1ns/1ps
`default_nettype none
module wsg_ext_dev
  import wsg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic acc_busy,
  input wire logic [4:0] stall,
  output logic ready
);
  // ************************************************************
  // Slow device: ready stays low for stall cycles of each access
  // ************************************************************
  logic [4:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (srst || !acc_busy) cnt_q <= 5'h00;
    else if (cnt_q != 5'h1f) cnt_q <= cnt_q + 5'h01;
  end
  assign ready = (cnt_q >= stall);
endmodule // wsg_ext_dev
`default_nettype wire

// file: tb/test_wsg_top.sv
// Self-checking bench for the wait-state generator
`timescale 1ns/1ps
`default_nettype none
module test_wsg_top;
  import wsg_pkg::*;
  logic sys_clk, srst, ready, bus_wait, acc_done, acc_busy, gen_clk_en, dbl_out, rd_d, dm;
  logic [15:0] mmr_rdata, cfg_out, cm, c, e;
  logic [4:0] stall;
  logic [15:0] rq[$];
  logic [15:0] lq[$];
  wsg_mmr_t memory_mapped_register;
  wsg_acc_t acc;
  int mismatches, compares, cyc, lat, wcnt;
  wsg_top uut (.sys_clk(sys_clk), .srst(srst), .memory_mapped_register(memory_mapped_register), .mmr_rdata(mmr_rdata), .acc(acc),
    .ready(ready), .bus_wait(bus_wait), .acc_done(acc_done), .acc_busy(acc_busy),
    .gen_clk_en(gen_clk_en), .cfg_out(cfg_out), .dbl_out(dbl_out));
  wsg_ext_dev dev (.sys_clk(sys_clk), .srst(srst), .acc_busy(acc_busy), .stall(stall),
    .ready(ready));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ************************************************************
  // Checks and report
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [4:0] wexp(logic [15:0] f, logic d, logic [1:0] sp, logic [22:0] a);
    logic [2:0] b;
    case (sp)
      2'h1: b = a[15] ? f[11:9] : f[8:6];
      2'h2: b = (f[15] ? a[22] : a[15]) ? f[5:3] : f[2:0];
      default: b = f[14:12];
    endcase
    return d ? {1'b0, b, 1'b0} : {2'h0, b};
  endfunction
  // ************************************************************
  // Drivers
  // ************************************************************
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    memory_mapped_register <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    if (a == WSG_CFG_ADDR) cm = d;
    if (a == WSG_CTRL_ADDR) dm = d[0];
    @(posedge sys_clk);
    memory_mapped_register.wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    memory_mapped_register <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    rq.push_back(exp);
    @(posedge sys_clk);
    memory_mapped_register.rd <= 1'b0;
  endtask
  task automatic go(input logic [1:0] sp, input logic [22:0] a, input logic [4:0] s);
    logic [4:0] n;
    int i;
    n = wexp(cm, dm, sp, a);
    lq.push_back(16'(((s > n) ? s : n) + 5'h01));
    @(posedge sys_clk);
    acc <= '{start: 1'b1, space: wsg_space_t'(sp), addr: a};
    stall <= s;
    @(posedge sys_clk);
    acc.start <= 1'b0;
    i = 0;
    do begin
      @(posedge sys_clk);
      #1;
      i++;
    end while (acc_busy !== 1'b0 && i < 60);
    chk({15'h0000, acc_busy}, 16'h0000);
  endtask
  // ************************************************************
  // Output watcher
  // ************************************************************
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rd_d <= memory_mapped_register.rd;
    if (rd_d) chk(mmr_rdata, rq.pop_front());
    if (acc.start && acc_busy === 1'b0) begin
      lat <= 1;
      wcnt <= 0;
    end else begin
      lat <= lat + 1;
      if (bus_wait === 1'b1) wcnt <= wcnt + 1;
    end
    if (acc_done === 1'b1) begin
      e = lq.pop_front();
      chk(16'(lat), e);
      chk(16'(wcnt), e - 16'h0001);
    end
    if (cyc == 30000) begin
      mismatches++;
      final_report();
    end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    srst = 1'b1;
    memory_mapped_register = '0;
    acc = '0;
    stall = 5'h00;
    cm = WSG_CFG_RST;
    dm = 1'b0;
    void'($urandom(89));
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(WSG_CFG_ADDR, 16'h7fff);
    rd(WSG_CTRL_ADDR, 16'h0000);
    rd(7'h29, 16'h0000);
    chk({15'h0000, cfg_out[15]}, 16'h0000);
    go(2'h1, 23'h000000, 5'h00);
    wr(WSG_CTRL_ADDR, 16'hffff);
    rd(WSG_CTRL_ADDR, 16'h0001);
    go(2'h2, 23'h7fffff, 5'h00);
    go(2'h0, 23'h001234, 5'h14);
    wr(WSG_CFG_ADDR, 16'h0000);
    #1;
    chk({15'h0000, gen_clk_en}, 16'h0000);
    go(2'h2, 23'h000000, 5'h00);
    for (int k = 0; k < 24; k++) begin
      c = 16'($urandom);
      wr(WSG_CFG_ADDR, c);
      wr(WSG_CTRL_ADDR, 16'($urandom));
      rd(WSG_CFG_ADDR, c);
      #1;
      chk({15'h0000, gen_clk_en}, {15'h0000, c[14:0] != 15'h0000});
      chk(cfg_out, c);
      chk({15'h0000, dbl_out}, {15'h0000, dm});
      go(2'($urandom), 23'($urandom), 5'($urandom % 18));
    end
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    cm = WSG_CFG_RST;
    dm = 1'b0;
    rd(WSG_CFG_ADDR, 16'h7fff);
    rd(WSG_CTRL_ADDR, 16'h0000);
    go(2'h0, 23'h000000, 5'h00);
    repeat (3) @(posedge sys_clk);
    chk(16'(lq.size() + rq.size()), 16'h0000);
    final_report();
  end
endmodule // test_wsg_top
`default_nettype wire
